/* File: hdl/io_buf_pkg.sv */
// Shared constants and types for the channel buffer control block
package io_buf_pkg;

  // Word layout
  localparam int WORD_W = 30;
  localparam int HALF_W = 15;
  localparam int ADDR_W = 17;
  localparam int IO_SR_W = 2;
  localparam int GEN_SR_W = 4;
  localparam int NCH_DEF = 16;
  localparam int CW_DEF = 4;

  // Buffer paths
  localparam int NPATH = 3;
  localparam int PATH_IN = 0;
  localparam int PATH_OUT = 1;
  localparam int PATH_EF = 2;

  // Control register bases, per channel offset added
  localparam logic [7:0] CTL_BASE_IN = 8'h40;
  localparam logic [7:0] CTL_BASE_OUT = 8'h50;
  localparam logic [7:0] CTL_BASE_EF = 8'h60;

  // Monitor interrupt entrance bases
  localparam logic [HALF_W-1:0] MON_BASE_IN = 15'h0020;
  localparam logic [HALF_W-1:0] MON_BASE_OUT = 15'h0030;
  localparam logic [HALF_W-1:0] MON_BASE_EF = 15'h0140;

  // Form codes of the buffer start instructions
  localparam logic [1:0] FORM_OPND = 2'h0;
  localparam logic [1:0] FORM_LOW = 2'h1;
  localparam logic [1:0] FORM_EF = 2'h2;
  localparam logic [1:0] FORM_WHOLE = 2'h3;

  // Form codes of the terminate instructions
  localparam logic [1:0] TERM_ONE = 2'h0;
  localparam logic [1:0] TERM_EFONE = 2'h1;
  localparam logic [1:0] TERM_ALL = 2'h2;

  // Instruction codes seen by the block
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_IN_BUF = 5'h01,
    OP_OUT_BUF = 5'h02,
    OP_TERM_IN = 5'h03,
    OP_TERM_OUT = 5'h04,
    OP_ENTER_SR = 5'h05,
    OP_ENTER_IN_SR = 5'h06,
    OP_ENTER_OUT_SR = 5'h07,
    OP_ENTER_EF_SR = 5'h08,
    OP_EN_IN_CDM = 5'h09,
    OP_EN_OUT_CDM = 5'h0a,
    OP_DIS_IN_CDM = 5'h0b,
    OP_DIS_OUT_CDM = 5'h0c,
    OP_STORE_SR = 5'h0d,
    OP_STORE_IN_SR = 5'h0e,
    OP_STORE_OUT_SR = 5'h0f,
    OP_STORE_EF_SR = 5'h10,
    OP_DIS_EXP = 5'h11,
    OP_EN_EXP = 5'h12
  } op_e;

  // Per-channel buffer state
  typedef enum logic [1:0] {
    CH_IDLE = 2'h1,
    CH_BUSY = 2'h2
  } ch_state_e;

endpackage

/* File: hdl/buf_if.sv */
// Link between the command decoder and one buffer path
`timescale 1ns/1ps
`default_nettype none
interface buf_if #(
  parameter int NCH = io_buf_pkg::NCH_DEF,
  parameter int CW = io_buf_pkg::CW_DEF
);
  logic load;
  logic lower_only;
  logic [CW-1:0] chan;
  logic [io_buf_pkg::WORD_W-1:0] value;
  logic monitor;
  logic term;
  logic term_all;
  logic [NCH-1:0] req;
  logic xfer_valid;
  logic [CW-1:0] xfer_chan;
  logic [io_buf_pkg::HALF_W-1:0] xfer_addr;
  logic done_valid;
  logic done_mon;
  logic [NCH-1:0] active;

  modport ctl (
    output load, lower_only, chan, value, monitor, term, term_all, req,
    input xfer_valid, xfer_chan, xfer_addr, done_valid, done_mon, active
  );
  modport path (
    input load, lower_only, chan, value, monitor, term, term_all, req,
    output xfer_valid, xfer_chan, xfer_addr, done_valid, done_mon, active
  );
endinterface
`default_nettype wire

/* File: hdl/buffer_path.sv */
// Control registers and word pacing for one buffer path
`timescale 1ns/1ps
`default_nettype none
module buffer_path #(
  parameter int NCH = io_buf_pkg::NCH_DEF,
  parameter int CW = io_buf_pkg::CW_DEF
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Decoder side
  buf_if.path bus
);
  localparam int HW = io_buf_pkg::HALF_W;
  localparam int WW = io_buf_pkg::WORD_W;

  logic [WW-1:0] ctl_r [NCH];
  io_buf_pkg::ch_state_e state_r [NCH];
  logic [NCH-1:0] mon_r;
  logic found;
  logic [CW-1:0] sel;
  logic [HW-1:0] nxt_low;
  logic chk_r;
  logic end_r;
  logic [CW-1:0] sel_r;
  logic [HW-1:0] exp_low_r;

  // Lowest requesting busy channel not being reloaded
  always_comb begin
    found = 1'b0;
    sel = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (bus.req[i] && state_r[i] == io_buf_pkg::CH_BUSY &&
          !bus.term_all &&
          !((bus.load || bus.term) && bus.chan == CW'(i))) begin
        found = 1'b1;
        sel = CW'(i);
      end
    end
  end

  assign nxt_low = ctl_r[sel][HW-1:0] + HW'(1);
  assign bus.xfer_valid = found;
  assign bus.xfer_chan = sel;
  assign bus.xfer_addr = ctl_r[sel][HW-1:0];
  assign bus.done_valid = found && (nxt_low == ctl_r[sel][WW-1:HW]);
  assign bus.done_mon = mon_r[sel];

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
        ctl_r[g] <= '0;
        state_r[g] <= io_buf_pkg::CH_IDLE;
        mon_r[g] <= 1'b0;
      end else if (bus.load && bus.chan == CW'(g)) begin
        if (bus.lower_only) begin
          ctl_r[g][HW-1:0] <= bus.value[HW-1:0];
        end else begin
          ctl_r[g] <= bus.value;
        end
        state_r[g] <= io_buf_pkg::CH_BUSY;
        mon_r[g] <= bus.monitor;
      end else if (bus.term_all || (bus.term && bus.chan == CW'(g))) begin
        state_r[g] <= io_buf_pkg::CH_IDLE;
      end else if (found && sel == CW'(g)) begin
        ctl_r[g][HW-1:0] <= nxt_low;
        if (nxt_low == ctl_r[g][WW-1:HW]) begin
          state_r[g] <= io_buf_pkg::CH_IDLE;
        end
      end
    end
    assign bus.active[g] = (state_r[g] == io_buf_pkg::CH_BUSY);
  end

  // Check helpers
  always_ff @(posedge i_clock) begin
    chk_r <= found;
    end_r <= bus.done_valid;
    sel_r <= sel;
    exp_low_r <= nxt_low;
  end

  a_addr_incr: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    chk_r |-> ctl_r[sel_r][HW-1:0] == exp_low_r)
    else $error("current address not advanced by one");
  a_end_equal: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (chk_r && end_r) |-> !bus.active[sel_r])
    else $error("buffer still active after halves matched");
  a_req_gate: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    bus.xfer_valid |-> bus.req[bus.xfer_chan])
    else $error("transfer without equipment request");
  a_load_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    bus.load |=> bus.active[$past(bus.chan)])
    else $error("buffer not started by load");
  a_term_all: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (bus.term_all && !bus.load) |=> bus.active == '0)
    else $error("buffer survived terminate all");
endmodule
`default_nettype wire

/* File: hdl/io_channel_buffer_control.sv */
// Instruction decoder, special registers and buffer paths per channel
`timescale 1ns/1ps
`default_nettype none
module io_channel_buffer_control #(
  parameter int NCH = io_buf_pkg::NCH_DEF,
  parameter int CW = io_buf_pkg::CW_DEF
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Instruction
  input wire logic i_cmd_valid,
  input wire io_buf_pkg::op_e i_cmd_code,
  input wire logic [CW-1:0] i_cmd_chan,
  input wire logic [1:0] i_cmd_form,
  input wire logic i_cmd_monitor,
  input wire logic [io_buf_pkg::WORD_W-1:0] i_cmd_operand,
  input wire logic [io_buf_pkg::WORD_W-1:0] i_cmd_word,
  input wire logic i_mode_switch,
  // Equipment requests
  input wire logic [NCH-1:0] i_in_req,
  input wire logic [NCH-1:0] i_out_req,
  input wire logic [NCH-1:0] i_ef_req,
  // Word transfers per path
  output logic [io_buf_pkg::NPATH-1:0] o_xfer_valid,
  output logic [io_buf_pkg::NPATH-1:0][CW-1:0] o_xfer_chan,
  output logic [io_buf_pkg::NPATH-1:0][io_buf_pkg::ADDR_W-1:0] o_xfer_addr,
  // Monitor interrupts per path
  output logic [io_buf_pkg::NPATH-1:0] o_mon_valid,
  output logic [io_buf_pkg::NPATH-1:0][io_buf_pkg::HALF_W-1:0] o_mon_addr,
  // Status
  output logic [NCH-1:0] o_in_active,
  output logic [NCH-1:0] o_out_active,
  output logic [NCH-1:0] o_ef_active,
  output logic [NCH-1:0] o_in_cdm,
  output logic [NCH-1:0] o_out_cdm,
  output logic o_expanded,
  output logic o_illegal,
  // Read-back
  output logic o_store_valid,
  output logic [io_buf_pkg::WORD_W-1:0] o_store_data
);
  localparam int NP = io_buf_pkg::NPATH;
  localparam int HW = io_buf_pkg::HALF_W;
  localparam int WW = io_buf_pkg::WORD_W;
  localparam int AW = io_buf_pkg::ADDR_W;
  localparam int SW = io_buf_pkg::IO_SR_W;
  localparam int GW = io_buf_pkg::GEN_SR_W;

  if (NCH < 1 || NCH > (1 << CW)) begin : g_bad
    $error("NCH must be between 1 and 2**CW");
  end

  logic [NP-1:0] load_v;
  logic [NP-1:0] term_v;
  logic [NP-1:0] term_all_v;
  logic lower_only;
  logic [WW-1:0] load_value;
  logic illegal_nxt;
  logic [SW-1:0] io_sr_r [NP][NCH];
  logic [GW-1:0] gen_sr_r [NCH];
  logic [NCH-1:0] in_cdm_r;
  logic [NCH-1:0] out_cdm_r;
  logic expanded_r;
  logic [NP-1:0][NCH-1:0] req_v;
  logic [NP-1:0][NCH-1:0] act_v;

  assign req_v[io_buf_pkg::PATH_IN] = i_in_req;
  assign req_v[io_buf_pkg::PATH_OUT] = i_out_req;
  assign req_v[io_buf_pkg::PATH_EF] = i_ef_req;

  // Buffer start and terminate decode
  always_comb begin
    load_v = '0;
    term_v = '0;
    term_all_v = '0;
    illegal_nxt = 1'b0;
    lower_only = (i_cmd_form == io_buf_pkg::FORM_OPND) ||
                 (i_cmd_form == io_buf_pkg::FORM_LOW);
    if (i_cmd_form == io_buf_pkg::FORM_OPND) begin
      load_value = {{(WW - HW){1'b0}}, i_cmd_operand[HW-1:0]};
    end else begin
      load_value = i_cmd_word;
    end
    if (i_cmd_valid) begin
      case (i_cmd_code)
        io_buf_pkg::OP_IN_BUF: begin
          if (i_cmd_form == io_buf_pkg::FORM_EF) begin
            illegal_nxt = 1'b1;
          end else begin
            load_v[io_buf_pkg::PATH_IN] = 1'b1;
          end
        end
        io_buf_pkg::OP_OUT_BUF: begin
          if (i_cmd_form == io_buf_pkg::FORM_EF) begin
            load_v[io_buf_pkg::PATH_EF] = 1'b1;
          end else begin
            load_v[io_buf_pkg::PATH_OUT] = 1'b1;
          end
        end
        io_buf_pkg::OP_TERM_IN: begin
          if (i_cmd_form == io_buf_pkg::TERM_ONE) begin
            term_v[io_buf_pkg::PATH_IN] = 1'b1;
          end
        end
        io_buf_pkg::OP_TERM_OUT: begin
          if (i_cmd_form == io_buf_pkg::TERM_ONE) begin
            term_v[io_buf_pkg::PATH_OUT] = 1'b1;
          end else if (i_cmd_form == io_buf_pkg::TERM_EFONE) begin
            term_v[io_buf_pkg::PATH_EF] = 1'b1;
          end else if (i_cmd_form == io_buf_pkg::TERM_ALL) begin
            term_all_v[io_buf_pkg::PATH_OUT] = 1'b1;
            term_all_v[io_buf_pkg::PATH_EF] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Buffer paths
  for (genvar p = 0; p < NP; p++) begin : g_path
    localparam logic [HW-1:0] MON_BASE =
      (p == io_buf_pkg::PATH_IN) ? io_buf_pkg::MON_BASE_IN :
      (p == io_buf_pkg::PATH_OUT) ? io_buf_pkg::MON_BASE_OUT :
      io_buf_pkg::MON_BASE_EF;
    buf_if #(.NCH(NCH), .CW(CW)) bus ();

    assign bus.load = load_v[p];
    assign bus.lower_only = lower_only;
    assign bus.chan = i_cmd_chan;
    assign bus.value = load_value;
    assign bus.monitor = i_cmd_monitor;
    assign bus.term = term_v[p];
    assign bus.term_all = term_all_v[p];
    assign bus.req = req_v[p];
    assign act_v[p] = bus.active;

    buffer_path #(.NCH(NCH), .CW(CW)) u_path (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .bus(bus)
    );

    always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
        o_xfer_valid[p] <= 1'b0;
        o_xfer_chan[p] <= '0;
        o_xfer_addr[p] <= '0;
      end else begin
        o_xfer_valid[p] <= bus.xfer_valid;
        o_xfer_chan[p] <= bus.xfer_chan;
        if (expanded_r) begin
          o_xfer_addr[p] <= {io_sr_r[p][bus.xfer_chan], bus.xfer_addr};
        end else begin
          o_xfer_addr[p] <= {{(AW - HW){1'b0}}, bus.xfer_addr};
        end
      end
    end

    always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
        o_mon_valid[p] <= 1'b0;
        o_mon_addr[p] <= '0;
      end else begin
        o_mon_valid[p] <= bus.done_valid && bus.done_mon;
        o_mon_addr[p] <= MON_BASE + HW'(bus.xfer_chan);
      end
    end
  end

  // Status outputs
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_in_active <= '0;
      o_out_active <= '0;
      o_ef_active <= '0;
      o_illegal <= 1'b0;
    end else begin
      o_in_active <= act_v[io_buf_pkg::PATH_IN];
      o_out_active <= act_v[io_buf_pkg::PATH_OUT];
      o_ef_active <= act_v[io_buf_pkg::PATH_EF];
      o_illegal <= illegal_nxt;
    end
  end

  // Channel address extension registers
  for (genvar c = 0; c < NCH; c++) begin : g_sr
    always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
        io_sr_r[io_buf_pkg::PATH_IN][c] <= '0;
        io_sr_r[io_buf_pkg::PATH_OUT][c] <= '0;
        io_sr_r[io_buf_pkg::PATH_EF][c] <= '0;
        gen_sr_r[c] <= '0;
      end else if (i_cmd_valid && i_cmd_chan == CW'(c)) begin
        if (i_cmd_code == io_buf_pkg::OP_ENTER_IN_SR) begin
          io_sr_r[io_buf_pkg::PATH_IN][c] <= i_cmd_operand[SW-1:0];
        end else if (i_cmd_code == io_buf_pkg::OP_ENTER_OUT_SR) begin
          io_sr_r[io_buf_pkg::PATH_OUT][c] <= i_cmd_operand[SW-1:0];
        end else if (i_cmd_code == io_buf_pkg::OP_ENTER_EF_SR) begin
          io_sr_r[io_buf_pkg::PATH_EF][c] <= i_cmd_operand[SW-1:0];
        end else if (i_cmd_code == io_buf_pkg::OP_ENTER_SR) begin
          gen_sr_r[c] <= i_cmd_operand[GW-1:0];
        end
      end
    end

    // Continuous data mode flags
    always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
        in_cdm_r[c] <= 1'b0;
        out_cdm_r[c] <= 1'b0;
      end else if (i_cmd_valid && i_cmd_chan == CW'(c)) begin
        case (i_cmd_code)
          io_buf_pkg::OP_EN_IN_CDM: in_cdm_r[c] <= 1'b1;
          io_buf_pkg::OP_EN_OUT_CDM: out_cdm_r[c] <= 1'b1;
          io_buf_pkg::OP_DIS_IN_CDM: in_cdm_r[c] <= 1'b0;
          io_buf_pkg::OP_DIS_OUT_CDM: out_cdm_r[c] <= 1'b0;
          io_buf_pkg::OP_ENTER_IN_SR: in_cdm_r[c] <= 1'b0;
          io_buf_pkg::OP_ENTER_OUT_SR: out_cdm_r[c] <= 1'b0;
          io_buf_pkg::OP_ENTER_EF_SR: out_cdm_r[c] <= 1'b0;
          default: begin
          end
        endcase
      end
    end
  end

  assign o_in_cdm = in_cdm_r;
  assign o_out_cdm = out_cdm_r;

  // Expanded addressing mode
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      expanded_r <= 1'b0;
    end else if (i_cmd_valid && i_cmd_code == io_buf_pkg::OP_DIS_EXP) begin
      expanded_r <= 1'b0;
    end else if (i_cmd_valid && i_cmd_code == io_buf_pkg::OP_EN_EXP &&
                 i_mode_switch) begin
      expanded_r <= 1'b1;
    end
  end

  assign o_expanded = expanded_r;

  // Read-back of extension registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_store_valid <= 1'b0;
      o_store_data <= '0;
    end else begin
      o_store_valid <= 1'b0;
      if (i_cmd_valid) begin
        case (i_cmd_code)
          io_buf_pkg::OP_STORE_SR: begin
            o_store_valid <= 1'b1;
            o_store_data <= WW'(gen_sr_r[i_cmd_chan]);
          end
          io_buf_pkg::OP_STORE_IN_SR: begin
            o_store_valid <= 1'b1;
            o_store_data <= WW'(io_sr_r[io_buf_pkg::PATH_IN][i_cmd_chan]);
          end
          io_buf_pkg::OP_STORE_OUT_SR: begin
            o_store_valid <= 1'b1;
            o_store_data <= WW'(io_sr_r[io_buf_pkg::PATH_OUT][i_cmd_chan]);
          end
          io_buf_pkg::OP_STORE_EF_SR: begin
            o_store_valid <= 1'b1;
            o_store_data <= WW'(io_sr_r[io_buf_pkg::PATH_EF][i_cmd_chan]);
          end
          default: begin
          end
        endcase
      end
    end
  end

  a_cdm_set: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_cmd_valid && i_cmd_code == io_buf_pkg::OP_EN_IN_CDM)
      |=> o_in_cdm[$past(i_cmd_chan)])
    else $error("input continuous mode not set");
  a_cdm_clear: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_cmd_valid && i_cmd_code == io_buf_pkg::OP_DIS_OUT_CDM)
      |=> !o_out_cdm[$past(i_cmd_chan)])
    else $error("output continuous mode not cleared");
  a_exp_mask: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (!expanded_r && !$past(expanded_r) && o_xfer_valid[0])
      |-> o_xfer_addr[0][AW-1:HW] == '0)
    else $error("extension bits used with expanded mode off");
  a_store_gen: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_cmd_valid && i_cmd_code == io_buf_pkg::OP_STORE_SR)
      |=> o_store_valid && o_store_data[GW-1:0] ==
          $past(gen_sr_r[i_cmd_chan]))
    else $error("general register read-back wrong");
endmodule
`default_nettype wire

/* File: verification/io_equipment_model.sv */
// Peripheral equipment model raising word requests per channel
`timescale 1ns/1ps
`default_nettype none
module io_equipment_model #(
  parameter int NCH = 16,
  parameter int CW = 4,
  parameter int GAP = 0
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Wish to move words, observed transfers
  input wire logic [NCH-1:0] i_want,
  input wire logic i_xfer_valid,
  input wire logic [CW-1:0] i_xfer_chan,
  // Word requests
  output logic [NCH-1:0] o_req
);
  logic [7:0] gap_r [NCH];

  // Request held until its word is seen, then paced by GAP
  always_ff @(posedge i_clock) begin
    for (int c = 0; c < NCH; c++) begin
      if (!i_rst_b) begin
        o_req[c] <= 1'b0;
        gap_r[c] <= 8'h00;
      end else if (i_xfer_valid && i_xfer_chan == CW'(c)) begin
        o_req[c] <= 1'b0;
        gap_r[c] <= 8'(GAP);
      end else if (gap_r[c] != 8'h00) begin
        gap_r[c] <= gap_r[c] - 8'h01;
      end else begin
        o_req[c] <= i_want[c];
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/io_channel_buffer_control_bench.sv */
// Self-checking bench for the channel buffer control block
`timescale 1ns/1ps
`default_nettype none
module io_channel_buffer_control_bench;
  localparam int NCH = 16;
  localparam int CW = 4;
  logic i_clock;
  logic i_rst_b;
  logic cmd_valid;
  io_buf_pkg::op_e cmd_code;
  logic [CW-1:0] cmd_chan;
  logic [1:0] cmd_form;
  logic cmd_monitor;
  logic [29:0] cmd_operand;
  logic [29:0] cmd_word;
  logic mode_switch;
  logic [2:0][NCH-1:0] want;
  logic [2:0][NCH-1:0] req;
  logic [2:0] xfer_valid;
  logic [2:0][CW-1:0] xfer_chan;
  logic [2:0][16:0] xfer_addr;
  logic [2:0] mon_valid;
  logic [2:0][14:0] mon_addr;
  logic [NCH-1:0] in_active, out_active, ef_active, in_cdm, out_cdm;
  logic expanded, illegal, store_valid;
  logic [29:0] store_data;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [16:0] xq[3][$];
  logic [14:0] mq[3][$];
  logic [CW-1:0] cq[3][$];

  io_channel_buffer_control #(.NCH(NCH), .CW(CW))
      io_channel_buffer_control_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_cmd_valid(cmd_valid),
    .i_cmd_code(cmd_code), .i_cmd_chan(cmd_chan), .i_cmd_form(cmd_form),
    .i_cmd_monitor(cmd_monitor), .i_cmd_operand(cmd_operand),
    .i_cmd_word(cmd_word), .i_mode_switch(mode_switch),
    .i_in_req(req[0]), .i_out_req(req[1]), .i_ef_req(req[2]),
    .o_xfer_valid(xfer_valid), .o_xfer_chan(xfer_chan),
    .o_xfer_addr(xfer_addr), .o_mon_valid(mon_valid), .o_mon_addr(mon_addr),
    .o_in_active(in_active), .o_out_active(out_active),
    .o_ef_active(ef_active), .o_in_cdm(in_cdm), .o_out_cdm(out_cdm),
    .o_expanded(expanded), .o_illegal(illegal),
    .o_store_valid(store_valid), .o_store_data(store_data));

  for (genvar p = 0; p < 3; p++) begin : g_eq
    io_equipment_model #(.NCH(NCH), .CW(CW), .GAP(p)) io_equipment_model_i (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_want(want[p]),
      .i_xfer_valid(xfer_valid[p]), .i_xfer_chan(xfer_chan[p]),
      .o_req(req[p]));
  end

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Transfer and interrupt log, cycle ceiling
  always @(posedge i_clock) begin
    cycles++;
    for (int p = 0; p < 3; p++) begin
      if (xfer_valid[p] === 1'b1) xq[p].push_back(xfer_addr[p]);
      if (xfer_valid[p] === 1'b1) cq[p].push_back(xfer_chan[p]);
      if (mon_valid[p] === 1'b1) mq[p].push_back(mon_addr[p]);
    end
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] seen, logic [31:0] ev);
    n_compared++;
    if (seen !== ev) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ev, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic cmd(io_buf_pkg::op_e c, int ch, logic [1:0] f = 2'h0,
                     logic m = 1'b0, logic [29:0] y = '0,
                     logic [29:0] w = '0);
    @(posedge i_clock);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_chan <= CW'(ch);
    cmd_form <= f;
    cmd_monitor <= m;
    cmd_operand <= y;
    cmd_word <= w;
    @(posedge i_clock);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic go(int p, int ch);
    @(posedge i_clock);
    want[p][ch] <= 1'b1;
  endtask

  task automatic settle();
    int n = 0;
    repeat (2) @(posedge i_clock);
    while ((in_active | out_active | ef_active) !== '0 && n < 300) begin
      @(posedge i_clock);
      n++;
    end
    check("settle", n < 300, 1);
    want <= '0;
    tick(2);
  endtask

  task automatic expect_path(int p, logic [16:0] a, int n, int nm,
                             logic [14:0] ma, int ch);
    check("xfer_count", xq[p].size(), n);
    for (int i = 0; i < xq[p].size(); i++) begin
      check("xfer_addr", xq[p][i], a + 17'(i));
      check("xfer_chan", cq[p][i], ch);
    end
    check("mon_count", mq[p].size(), nm);
    if (nm > 0) check("mon_addr", mq[p][0], ma);
    xq[p].delete();
    cq[p].delete();
    mq[p].delete();
  endtask

  initial begin
    i_rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = io_buf_pkg::OP_NONE;
    cmd_chan = '0;
    cmd_form = 2'h0;
    cmd_monitor = 1'b0;
    cmd_operand = '0;
    cmd_word = '0;
    mode_switch = 1'b0;
    want = '0;
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
    tick(1);
    check("rst_active", |{in_active, out_active, ef_active}, 0);
    check("rst_expanded", expanded, 0);
    $display("test reset done");
    cmd(io_buf_pkg::OP_IN_BUF, 2, 2'h3, 1, 0, {15'h0103, 15'h0100});
    tick(1);
    check("in_active", in_active[2], 1);
    go(0, 2);
    settle();
    expect_path(0, 17'h100, 3, 1, 15'h22, 2);
    cmd(io_buf_pkg::OP_IN_BUF, 3, 2'h3, 0, 0, {15'h0210, 15'h0200});
    cmd(io_buf_pkg::OP_IN_BUF, 3, 2'h1, 0, 0, {15'h7777, 15'h020e});
    cmd(io_buf_pkg::OP_IN_BUF, 3, 2'h0, 0, 30'h20c);
    go(0, 3);
    settle();
    expect_path(0, 17'h20c, 4, 0, 0, 3);
    cmd(io_buf_pkg::OP_IN_BUF, 3, 2'h2, 0, 0, {15'h0210, 15'h0200});
    check("illegal", illegal, 1);
    tick(2);
    check("illegal_idle", in_active, 0);
    $display("test input done");
    cmd(io_buf_pkg::OP_OUT_BUF, 1, 2'h3, 1, 0, {15'h0305, 15'h0300});
    cmd(io_buf_pkg::OP_OUT_BUF, 4, 2'h2, 1, 0, {15'h0402, 15'h0400});
    tick(1);
    check("out_start", {out_active, ef_active}, {16'h0002, 16'h0010});
    go(1, 1);
    go(2, 4);
    settle();
    expect_path(1, 17'h300, 5, 1, 15'h31, 1);
    expect_path(2, 17'h400, 2, 1, 15'h144, 4);
    $display("test output done");
    cmd(io_buf_pkg::OP_IN_BUF, 5, 2'h3, 1, 0, {15'h0540, 15'h0500});
    go(0, 5);
    cmd(io_buf_pkg::OP_TERM_IN, 5);
    settle();
    check("term_words", xq[0].size(), 0);
    check("term_mon", mq[0].size(), 0);
    xq[0].delete();
    cq[0].delete();
    cmd(io_buf_pkg::OP_OUT_BUF, 6, 2'h3, 1, 0, {15'h0610, 15'h0600});
    cmd(io_buf_pkg::OP_OUT_BUF, 7, 2'h2, 1, 0, {15'h0710, 15'h0700});
    cmd(io_buf_pkg::OP_OUT_BUF, 11, 2'h3, 1, 0, {15'h0b10, 15'h0b00});
    cmd(io_buf_pkg::OP_TERM_OUT, 6, 2'h0);
    cmd(io_buf_pkg::OP_TERM_OUT, 7, 2'h1);
    tick(1);
    check("term_one", {out_active, ef_active}, {16'h0800, 16'h0000});
    cmd(io_buf_pkg::OP_TERM_OUT, 0, 2'h2);
    settle();
    check("all_mon", mq[1].size() + mq[2].size(), 0);
    $display("test terminate done");
    cmd(io_buf_pkg::OP_EN_IN_CDM, 8, 2'h3, 1, '1, '1);
    check("in_cdm", in_cdm[8], 1);
    cmd(io_buf_pkg::OP_EN_OUT_CDM, 8);
    check("out_cdm", out_cdm[8], 1);
    cmd(io_buf_pkg::OP_ENTER_IN_SR, 8, 2'h0, 0, 30'h3ffffffe);
    check("in_cdm_clr", {in_cdm[8], out_cdm[8]}, 2'h1);
    cmd(io_buf_pkg::OP_STORE_IN_SR, 8);
    check("in_sr", {store_valid, store_data}, {1'b1, 30'h2});
    cmd(io_buf_pkg::OP_ENTER_OUT_SR, 8, 2'h0, 0, 30'h3ffffff5);
    check("out_cdm_clr", out_cdm[8], 0);
    cmd(io_buf_pkg::OP_STORE_OUT_SR, 8);
    check("out_sr", store_data, 30'h1);
    cmd(io_buf_pkg::OP_EN_OUT_CDM, 8);
    cmd(io_buf_pkg::OP_ENTER_EF_SR, 8, 2'h0, 0, 30'h7);
    check("ef_cdm_clr", out_cdm[8], 0);
    cmd(io_buf_pkg::OP_STORE_EF_SR, 8);
    check("ef_sr", store_data, 30'h3);
    cmd(io_buf_pkg::OP_EN_IN_CDM, 9);
    cmd(io_buf_pkg::OP_EN_OUT_CDM, 9);
    cmd(io_buf_pkg::OP_DIS_IN_CDM, 9, 2'h3, 1, '1);
    cmd(io_buf_pkg::OP_DIS_OUT_CDM, 9);
    check("cdm_off", {in_cdm, out_cdm}, 0);
    cmd(io_buf_pkg::OP_ENTER_SR, 9, 2'h0, 0, 30'h3ffffffa);
    cmd(io_buf_pkg::OP_STORE_SR, 9);
    check("gen_sr", store_data, 30'ha);
    $display("test special done");
    cmd(io_buf_pkg::OP_EN_EXP, 0);
    check("exp_refused", expanded, 0);
    @(posedge i_clock);
    mode_switch <= 1'b1;
    cmd(io_buf_pkg::OP_EN_EXP, 0);
    check("exp_on", expanded, 1);
    cmd(io_buf_pkg::OP_ENTER_OUT_SR, 10, 2'h0, 0, 30'h2);
    cmd(io_buf_pkg::OP_OUT_BUF, 10, 2'h3, 0, 0, {15'h0002, 15'h0001});
    go(1, 10);
    settle();
    expect_path(1, 17'h10001, 1, 0, 0, 10);
    cmd(io_buf_pkg::OP_DIS_EXP, 0);
    check("exp_off", expanded, 0);
    cmd(io_buf_pkg::OP_OUT_BUF, 10, 2'h3, 0, 0, {15'h0002, 15'h0001});
    go(1, 10);
    settle();
    expect_path(1, 17'h00001, 1, 0, 0, 10);
    $display("test expanded done");
    print_verdict();
  end
endmodule
`default_nettype wire
